// *** sim/tb_top.sv ***
// self-checking bench for the vlan ingress check control block
`timescale 1ns/1ps
`include "vlan_check_defs.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  $display("unexpected %s exp %h got %h", nm, ex, got); \
  fail_count++; end end

module tb_top;
  import vlan_check_pkg::*;
  logic i_clk = 0;
  logic i_reset = 1;
  logic i_read = 0;
  logic i_write = 0;
  logic i_mgmt_mode = 0;
  logic [7:0] i_address = 8'h00;
  logic [31:0] i_writedata = 32'h0;
  logic [3:0] i_byteenable = 4'hf;
  logic [1:0] i_mgmt_port_select = 2'h0;
  frame_in_s i_frame = '0;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic o_double_tag_mode;
  logic [1:0] o_ingress_membership_check;
  verdict_s o_verdict;
  verdict_s exp_q[$];
  verdict_s vx;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] ctrl_m = `VIC_CTRL_RESET;
  logic [31:0] rd;

  vlan_ingress_check_control u_vlan_ingress_check_control (
    .i_clk(i_clk), .i_reset(i_reset), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_mgmt_mode(i_mgmt_mode),
    .i_mgmt_port_select(i_mgmt_port_select), .i_frame(i_frame),
    .o_verdict(o_verdict),
    .o_ingress_membership_check(o_ingress_membership_check),
    .o_double_tag_mode(o_double_tag_mode)
  );

  always #5 i_clk = ~i_clk;

  // whole run needs well under 5000 cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // request held until waitrequest is sampled low at a rising edge;
  // data taken and request released at that same edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge i_clk);
    i_read <= ~w;
    i_write <= w;
    i_address <= a;
    i_writedata <= d;
    i_byteenable <= be;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] d);
    bus(1'b1, `VIC_CTRL_ADDR, {24'h0, d}, 4'hf);
    ctrl_m = d & `VIC_CTRL_WMASK;
  endtask

  task automatic do_reset;
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    ctrl_m = `VIC_CTRL_RESET;
  endtask

  function automatic verdict_s expv(frame_in_s f, logic [7:0] c,
                                    logic mm, logic [1:0] sel);
    verdict_s v;
    logic ms, rsv, dt, pre;
    logic [1:0] md;
    v = '0;
    md = c[7:6];
    pre = f.dest_mac[47:8] == `VIC_RSV_PREFIX;
    ms = f.src_port == `VIC_MGMT_PORT ||
         (sel == `VIC_DUAL_MGMT && f.src_port == `VIC_DUAL_PORT);
    rsv = pre && f.dest_mac[7:0] <= `VIC_RSV_LAST &&
          f.dest_mac[7:0] != `VIC_RSV_HOLE;
    dt = c[3:2] == `VIC_DT_ON;
    v.valid = 1'b1;
    v.violation = !ms && md != `VIC_CHK_BYPASS && !f.member_map[f.src_port];
    v.drop = v.violation && md == `VIC_CHK_DROP;
    v.learn = !v.violation;
    v.double_tag = dt;
    v.to_mgmt = (v.violation && md == `VIC_CHK_TO_MGMT) ||
      (pre && f.dest_mac[7:0] == `VIC_GVRP_LSB && c[5]) ||
      (pre && f.dest_mac[7:0] == `VIC_GMRP_LSB && c[4]) ||
      (dt && mm && rsv && !c[1]);
    v.flood_reserved = dt && mm && rsv && c[1] && !v.drop;
    if (v.drop)
      v.to_mgmt = 1'b0;
    return v;
  endfunction

  // watcher: any verdict seen retires the oldest note
  always @(negedge i_clk) begin
    if (!i_reset && o_verdict !== '0) begin
      vx = (exp_q.size() > 0) ? exp_q.pop_front() : verdict_s'('0);
      `CHK("verdict", vx, o_verdict)
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    frame_in_s f;
    logic [7:0] c;
    static logic [7:0] lsb [7] = '{8'h00, 8'h01, 8'h02, 8'h2f, 8'h30,
                                   8'h20, 8'h21};
    int p;
    int n_viol;
    verdict_s last_v;
    void'($urandom(32'he5fc));
    n_viol = 0;
    last_v = '0;
    do_reset();
    bus(1'b0, `VIC_CTRL_ADDR, 32'h0, 4'hf);
    `CHK("ctrl reset", {24'h0, `VIC_CTRL_RESET}, rd)
    bus(1'b0, `VIC_STATUS_ADDR, 32'h0, 4'hf);
    `CHK("status reset", 32'h0, rd)
    $display("test reset done");
    wr(8'hff);
    bus(1'b0, `VIC_CTRL_ADDR, 32'h0, 4'hf);
    `CHK("ctrl bit0", 32'h000000fe, rd)
    bus(1'b1, `VIC_CTRL_ADDR, 32'h0, 4'h0);
    bus(1'b1, 8'h20, 32'hffffffff, 4'hf);
    bus(1'b1, `VIC_STATUS_ADDR, 32'hffffffff, 4'hf);
    bus(1'b0, `VIC_STATUS_ADDR, 32'h0, 4'hf);
    `CHK("status read only", 32'h0, rd)
    bus(1'b0, 8'h20, 32'h0, 4'hf);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b0, `VIC_CTRL_ADDR, 32'h0, 4'hf);
    `CHK("ctrl kept", 32'h000000fe, rd)
    $display("test regs done");
    for (int k = 0; k < 16; k++) begin
      c = 8'($urandom);
      c[7:6] = k[1:0];
      if (k < 8)
        c[3:2] = `VIC_DT_ON;
      wr(c);
      @(negedge i_clk);
      `CHK("check field", ctrl_m[7:6], o_ingress_membership_check)
      `CHK("double_tag_mode", ctrl_m[3:2] == `VIC_DT_ON, o_double_tag_mode)
      for (int n = 0; n < 24; n++) begin
        @(posedge i_clk);
        f.valid = 1'b1;
        f.src_port = 4'($urandom_range(8));
        f.member_map = 9'($urandom);
        p = $urandom_range(7);
        f.dest_mac = (p == 7) ? {$urandom, 16'($urandom)} :
                     {`VIC_RSV_PREFIX, lsb[p]};
        c[0] = 1'($urandom);
        c[2:1] = 2'($urandom);
        i_frame <= f;
        i_mgmt_mode <= c[0];
        i_mgmt_port_select <= c[2:1];
        last_v = expv(f, ctrl_m, c[0], c[2:1]);
        exp_q.push_back(last_v);
        n_viol += last_v.violation;
      end
      @(posedge i_clk);
      i_frame <= '0;
      repeat (3) @(posedge i_clk);
    end
    `CHK("pending", 0, exp_q.size())
    bus(1'b0, `VIC_STATUS_ADDR, 32'h0, 4'hf);
    `CHK("status", {n_viol[15:0], 9'h0, last_v}, rd)
    $display("test frames done");
    do_reset();
    bus(1'b0, `VIC_CTRL_ADDR, 32'h0, 4'hf);
    `CHK("ctrl reset again", {24'h0, `VIC_CTRL_RESET}, rd)
    bus(1'b0, `VIC_STATUS_ADDR, 32'h0, 4'hf);
    `CHK("status reset again", 32'h0, rd)
    $display("test second reset done");
    give_verdict();
  end
endmodule // tb_top

// *** verilog/reserved_group_classifier.sv ***
// classifies a destination address as reserved group, gvrp or gmrp
`timescale 1ns/1ps
`include "vlan_check_defs.svh"

module reserved_group_classifier (
  input wire logic [47:0] i_dest_mac,
  output logic o_reserved,
  output logic o_gvrp,
  output logic o_gmrp
);

  logic prefix_hit;
  logic [7:0] low_byte;

  assign prefix_hit = (i_dest_mac[47:8] == `VIC_RSV_PREFIX);
  assign low_byte = i_dest_mac[7:0];

  // 00 and 02..2f are reserved, 01 (pause) is not
  assign o_reserved = prefix_hit && (low_byte <= `VIC_RSV_LAST) &&
                      (low_byte != `VIC_RSV_HOLE);
  assign o_gmrp = prefix_hit && (low_byte == `VIC_GMRP_LSB);
  assign o_gvrp = prefix_hit && (low_byte == `VIC_GVRP_LSB);

endmodule // reserved_group_classifier

// *** verilog/vlan_check_defs.svh ***
// constants for the vlan ingress check control block
`ifndef VLAN_CHECK_DEFS_SVH
`define VLAN_CHECK_DEFS_SVH

// word addresses on the register bus, control reset value and write mask
`define VIC_CTRL_ADDR 8'h05
`define VIC_STATUS_ADDR 8'h10
`define VIC_CTRL_RESET 8'hc0
`define VIC_CTRL_WMASK 8'hfe

// field positions of the control register
`define VIC_CHECK_HI 7
`define VIC_CHECK_LO 6
`define VIC_GVRP_BIT 5
`define VIC_GMRP_BIT 4
`define VIC_DT_HI 3
`define VIC_DT_LO 2
`define VIC_FLOOD_BIT 1

// membership check field encodings
`define VIC_CHK_FWD_NOLEARN 2'h0
`define VIC_CHK_DROP 2'h1
`define VIC_CHK_BYPASS 2'h2
`define VIC_CHK_TO_MGMT 2'h3

`define VIC_DT_ON 2'h1
`define VIC_DUAL_MGMT 2'h3

// port numbering
`define VIC_MGMT_PORT 4'h8
`define VIC_DUAL_PORT 4'h5

// reserved group addresses 01-80-c2-00-00-xx
`define VIC_RSV_PREFIX 40'h0180c20000
`define VIC_RSV_LAST 8'h2f
`define VIC_RSV_HOLE 8'h01
`define VIC_GMRP_LSB 8'h20
`define VIC_GVRP_LSB 8'h21

`endif

// *** verilog/vlan_check_pkg.sv ***
// types shared by the vlan ingress check control block
package vlan_check_pkg;

  // one frame descriptor from the lookup stage
  typedef struct packed {
    logic valid;
    logic [3:0] src_port;
    logic [8:0] member_map;
    logic [47:0] dest_mac;
  } frame_in_s;

  // per-frame forwarding verdict
  typedef struct packed {
    logic valid;
    logic violation;
    logic drop;
    logic to_mgmt;
    logic learn;
    logic flood_reserved;
    logic double_tag;
  } verdict_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_e;

endpackage

// *** verilog/vlan_ingress_check_control.sv ***
// vlan ingress check control register and per-frame verdict logic
//
// Function
// - flag violation when source not in map
// - mode 00: forward violator, do not learn
// - mode 01: drop violating frames
// - mode 10: skip check, always learn
// - mode 11 default: violator to management, no learn
// - no check on management port sources
// - bit 5 sends gvrp to management
// - bit 4 sends gmrp to management
// - double tag field: 00 off, 01 on
// - double tag management mode: flood or trap
// - reserved group is 00 and 02..2f
// - bit 0 reserved, reads zero
`timescale 1ns/1ps
`include "vlan_check_defs.svh"

module vlan_ingress_check_control (
  input wire logic i_clk,
  input wire logic i_reset,
  // avalon-mm slave, word addressed, 32-bit data
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // switch context
  input wire logic i_mgmt_mode,
  input wire logic [1:0] i_mgmt_port_select,
  // frame descriptors in, verdicts out one cycle later
  input wire vlan_check_pkg::frame_in_s i_frame,
  output vlan_check_pkg::verdict_s o_verdict,
  output logic [1:0] o_ingress_membership_check,
  output logic o_double_tag_mode
);

  import vlan_check_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic is_mgmt_source(input logic [3:0] port,
                                          input logic [1:0] sel);
    is_mgmt_source = (port == `VIC_MGMT_PORT) ||
                     ((port == `VIC_DUAL_PORT) && (sel == `VIC_DUAL_MGMT));
  endfunction

  function automatic logic in_member_map(input logic [8:0] map,
                                         input logic [3:0] port);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (port == 4'(i)) begin
        hit = map[i];
      end
    end
    in_member_map = hit;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // register bus

  bus_state_e state_q;
  bus_state_e state_d;
  logic [7:0] ctrl_q;
  logic [31:0] readdata_q;
  logic request;
  logic hit_ctrl;
  logic hit_status;
  logic [6:0] last_verdict_q;
  logic [15:0] violation_count_q;

  assign request = i_read || i_write;
  assign hit_ctrl = (i_address == `VIC_CTRL_ADDR);
  assign hit_status = (i_address == `VIC_STATUS_ADDR);

  // one wait cycle: data are latched in idle and answered in the next
  always_comb begin
    case (state_q)
      BUS_IDLE: state_d = request ? BUS_ANSWER : BUS_IDLE;
      BUS_ANSWER: state_d = BUS_IDLE;
      default: state_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= BUS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_waitrequest = request && (state_q != BUS_ANSWER);

  // reserved bit 0 is never stored so it always reads zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_q <= `VIC_CTRL_RESET;
    end else if (state_q == BUS_ANSWER && i_write && hit_ctrl &&
                 i_byteenable[0]) begin
      ctrl_q <= i_writedata[7:0] & `VIC_CTRL_WMASK;
    end
  end

  // unmapped addresses read zero and ignore writes
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      readdata_q <= 32'h0;
    end else if (state_q == BUS_IDLE && i_read) begin
      if (hit_ctrl) begin
        readdata_q <= {24'h0, ctrl_q};
      end else if (hit_status) begin
        readdata_q <= {violation_count_q, 9'h0, last_verdict_q};
      end else begin
        readdata_q <= 32'h0;
      end
    end
  end

  assign o_readdata = readdata_q;

  //////////////////////////////////////////////////////////////////////////
  // configuration decode

  logic [1:0] check_mode;
  logic [1:0] dt_field;
  logic dt_on;

  assign check_mode = ctrl_q[`VIC_CHECK_HI:`VIC_CHECK_LO];
  assign dt_field = ctrl_q[`VIC_DT_HI:`VIC_DT_LO];
  // 1x codes are treated as off so behaviour stays defined
  assign dt_on = (dt_field == `VIC_DT_ON);
  assign o_ingress_membership_check = check_mode;
  assign o_double_tag_mode = dt_on;

  //////////////////////////////////////////////////////////////////////////
  // frame verdict

  logic is_reserved;
  logic is_gvrp;
  logic is_gmrp;
  logic from_mgmt;
  logic violation;
  verdict_s verdict_d;
  verdict_s verdict_q;

  reserved_group_classifier u_classifier (
    .i_dest_mac(i_frame.dest_mac),
    .o_reserved(is_reserved),
    .o_gvrp(is_gvrp),
    .o_gmrp(is_gmrp)
  );

  assign from_mgmt = is_mgmt_source(i_frame.src_port,
                                    i_mgmt_port_select);
  assign violation = !from_mgmt && (check_mode != `VIC_CHK_BYPASS) &&
      !in_member_map(i_frame.member_map, i_frame.src_port);

  always_comb begin
    verdict_d = '0;
    verdict_d.valid = i_frame.valid;
    verdict_d.violation = violation;
    verdict_d.double_tag = dt_on;
    verdict_d.learn = 1'b1;
    if (violation) begin
      case (check_mode)
        `VIC_CHK_FWD_NOLEARN: verdict_d.learn = 1'b0;
        `VIC_CHK_DROP: begin
          verdict_d.drop = 1'b1;
          verdict_d.learn = 1'b0;
        end
        `VIC_CHK_TO_MGMT: begin
          verdict_d.to_mgmt = 1'b1;
          verdict_d.learn = 1'b0;
        end
        default: verdict_d.learn = 1'b1;
      endcase
    end
    if (is_gvrp && ctrl_q[`VIC_GVRP_BIT]) begin
      verdict_d.to_mgmt = 1'b1;
    end
    if (is_gmrp && ctrl_q[`VIC_GMRP_BIT]) begin
      verdict_d.to_mgmt = 1'b1;
    end
    if (dt_on && i_mgmt_mode && is_reserved) begin
      if (ctrl_q[`VIC_FLOOD_BIT]) begin
        verdict_d.flood_reserved = 1'b1;
      end else begin
        verdict_d.to_mgmt = 1'b1;
      end
    end
    // a drop overrides any management redirect
    if (verdict_d.drop) begin
      verdict_d.to_mgmt = 1'b0;
      verdict_d.flood_reserved = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      verdict_q <= '0;
    end else begin
      verdict_q <= i_frame.valid ? verdict_d : '0;
    end
  end

  assign o_verdict = verdict_q;

  // status: last verdict and a saturating violation counter
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      last_verdict_q <= '0;
    end else if (verdict_q.valid) begin
      last_verdict_q <= verdict_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      violation_count_q <= 16'h0;
    end else if (verdict_q.valid && verdict_q.violation &&
                 violation_count_q != 16'hffff) begin
      violation_count_q <= violation_count_q + 16'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  sequence frame_violates;
    i_frame.valid && !from_mgmt && (check_mode != `VIC_CHK_BYPASS) &&
      !in_member_map(i_frame.member_map, i_frame.src_port);
  endsequence

  sequence bus_request_idle;
    request && state_q == BUS_IDLE;
  endsequence

  sequence bus_answer;
    !o_waitrequest && state_q == BUS_ANSWER;
  endsequence

  violation_flag_a: assert property (
    frame_violates |=> o_verdict.valid && o_verdict.violation)
    else $error("membership violation not flagged");

  mode_fwd_nolearn_a: assert property (
    frame_violates and (check_mode == `VIC_CHK_FWD_NOLEARN)
    |=> !o_verdict.drop && !o_verdict.learn)
    else $error("mode 00 violator not forwarded without learning");

  mode_drop_a: assert property (
    frame_violates and (check_mode == `VIC_CHK_DROP)
    |=> o_verdict.drop && !o_verdict.to_mgmt)
    else $error("mode 01 violator not dropped");

  mode_bypass_a: assert property (
    i_frame.valid && check_mode == `VIC_CHK_BYPASS
    |=> o_verdict.learn && !o_verdict.violation && !o_verdict.drop)
    else $error("mode 10 did not bypass and learn");

  mode_to_mgmt_a: assert property (
    frame_violates and (check_mode == `VIC_CHK_TO_MGMT)
    |=> o_verdict.to_mgmt && !o_verdict.learn)
    else $error("mode 11 violator not sent to management");

  mgmt_source_a: assert property (
    i_frame.valid && (i_frame.src_port == `VIC_MGMT_PORT ||
      (i_frame.src_port == `VIC_DUAL_PORT &&
       i_mgmt_port_select == `VIC_DUAL_MGMT))
    |=> !o_verdict.violation && !o_verdict.drop)
    else $error("management source was checked");

  // port 5 stays an ordinary data port unless dual management is chosen
  port5_checked_a: assert property (
    i_frame.valid && i_frame.src_port == `VIC_DUAL_PORT &&
    i_mgmt_port_select != `VIC_DUAL_MGMT &&
    check_mode != `VIC_CHK_BYPASS && !i_frame.member_map[`VIC_DUAL_PORT]
    |=> o_verdict.violation)
    else $error("port 5 violation missed outside dual management");

  // gvrp and gmrp addresses sit in the reserved range, so the double tag
  // trap may also redirect them; that case is left to reserved_flood_a
  gvrp_steer_a: assert property (
    i_frame.valid && is_gvrp && !violation && !(dt_on && i_mgmt_mode)
    |=> o_verdict.to_mgmt == $past(ctrl_q[`VIC_GVRP_BIT]))
    else $error("gvrp steering wrong");

  gmrp_steer_a: assert property (
    i_frame.valid && is_gmrp && !violation && !(dt_on && i_mgmt_mode)
    |=> o_verdict.to_mgmt == $past(ctrl_q[`VIC_GMRP_BIT]))
    else $error("gmrp steering wrong");

  double_tag_a: assert property (
    i_frame.valid && ctrl_q[`VIC_DT_HI:`VIC_DT_LO] == `VIC_DT_ON
    |=> o_verdict.double_tag)
    else $error("double tag mode not applied to frame");

  dt_reserved_off_a: assert property (
    i_frame.valid && ctrl_q[`VIC_DT_HI] |=> !o_verdict.double_tag)
    else $error("reserved double tag code did not act as off");

  reserved_flood_a: assert property (
    i_frame.valid && dt_on && i_mgmt_mode && is_reserved && !violation &&
    !(is_gvrp && ctrl_q[`VIC_GVRP_BIT]) &&
    !(is_gmrp && ctrl_q[`VIC_GMRP_BIT])
    |=> o_verdict.flood_reserved == $past(ctrl_q[`VIC_FLOOD_BIT]) &&
        o_verdict.to_mgmt != $past(ctrl_q[`VIC_FLOOD_BIT]))
    else $error("reserved multicast flood or trap wrong");

  reserved_range_a: assert property (
    (i_frame.dest_mac[47:8] == `VIC_RSV_PREFIX &&
     i_frame.dest_mac[7:0] == `VIC_RSV_HOLE) |-> !is_reserved)
    else $error("pause address classed as reserved");

  bit0_zero_a: assert property (
    bus_request_idle and (i_read && hit_ctrl)
    |=> bus_answer ##0 (o_readdata[0] == 1'b0))
    else $error("reserved bit 0 read back nonzero");

  bus_answer_a: assert property (
    bus_request_idle |=> bus_answer ##1 (state_q == BUS_IDLE))
    else $error("bus answer not given in one wait cycle");

  ctrl_write_a: assert property (
    bus_answer and (i_write && hit_ctrl && i_byteenable[0])
    |=> ctrl_q == ($past(i_writedata[7:0]) & `VIC_CTRL_WMASK))
    else $error("control write not stored");

  // no frame in, nothing out: the verdict is a one-cycle pulse
  verdict_idle_a: assert property (
    !i_frame.valid |=> o_verdict == '0)
    else $error("verdict shown without a frame");

  drop_exclusive_a: assert property (
    o_verdict.drop |-> !o_verdict.to_mgmt && !o_verdict.flood_reserved &&
      !o_verdict.learn)
    else $error("dropped frame also redirected or learnt");

  reset_value_a: assert property (
    $past(i_reset) |-> ctrl_q == `VIC_CTRL_RESET)
    else $error("control register not at its reset value");

endmodule // vlan_ingress_check_control
